// [dv/scr_host.sv]
// Serial host model: mode-0 frames, 160 ns serial clock.
// Assumes the bench sets lsb, four and wd before each frame.
`timescale 1ns/1ps
`default_nettype none
module scr_host (
   // Clock
   input wire logic clk_i,
   // Lines from the device
   input wire logic sd_i,
   input wire logic so_i,
   // Serial pins
   output logic sclk_o,
   output logic cs_n_o,
   output logic sdio_o
);
   logic lsb = 1'b0;
   logic four = 1'b0;
   logic [7:0] wd [0:3];
   logic [7:0] rbyte;
   event got;
   // Idle levels
   initial begin
      sclk_o = 1'b0;
      cs_n_o = 1'b1;
      sdio_o = 1'b0;
   end
   // Drive on fall, sample at rise
   task automatic bit_io(input logic v, output logic r);
      sdio_o = v;
      repeat (20) @(negedge clk_i);
      r = four ? so_i : sd_i;
      sclk_o = 1'b1;
      repeat (20) @(negedge clk_i);
      sclk_o = 1'b0;
   endtask
   // Instruction then n data bytes
   task automatic frame(input logic rd, input logic [14:0] a, input int n);
      logic [15:0] ins;
      logic [7:0] b;
      logic r;
      ins = {rd, a};
      @(negedge clk_i);
      cs_n_o = 1'b0;
      for (int i = 0; i < 16; i++) begin
         bit_io(ins[lsb ? i : 15 - i], r);
      end
      for (int j = 0; j < n; j++) begin
         for (int k = 0; k < 8; k++) begin
            bit_io(rd ? ~sdio_o : wd[j][lsb ? k : 7 - k], r);
            b[lsb ? k : 7 - k] = r;
         end
         if (rd) begin
            rbyte = b;
            -> got;
         end
      end
      repeat (20) @(negedge clk_i);
      cs_n_o = 1'b1;
      sdio_o = ~sdio_o;
      repeat (40) @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

// [dv/scr_top_properties.sv]
// Checker for the serial bank: timing relations at the top ports.
// Assumes it is bound into scr_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "scr_defs.vh"
module scr_chk (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Serial pins
   input wire logic cs_n_i,
   input wire logic sdio_oe_o,
   input wire logic serial_out_pin_oe_o,
   // Settings
   input wire logic wire_count_select_o,
   input wire logic addr_ascend_o,
   input wire logic lsb_first_o,
   input wire logic single_instruction_o,
   input wire logic readback_main_o,
   input wire logic soft_reset_o,
   // External register port
   input wire logic ext_wr_o,
   input wire logic [`SCR_AW-1:0] ext_addr_o
);
   logic [3:0] wr_cnt;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // External writes within the current frame
   always @(posedge clk_i) begin
      if (rst_i || cs_n_i) begin
         wr_cnt <= 4'h0;
      end else if (ext_wr_o && wr_cnt != 4'hF) begin
         wr_cnt <= wr_cnt + 4'h1;
      end
   end
   AST_OE_THREE: assert property (sdio_oe_o |-> !wire_count_select_o)
      else $error("data pin driven in 4-wire mode");
   AST_OE_FOUR: assert property (serial_out_pin_oe_o |-> wire_count_select_o)
      else $error("output pin driven in 3-wire mode");
   AST_OE_RELEASE: assert property (cs_n_i [*6] |-> !sdio_oe_o && !serial_out_pin_oe_o)
      else $error("pin driven outside a frame");
   AST_ADDR_STEP: assert property (ext_wr_o && !single_instruction_o |=>
      ext_addr_o == ($past(addr_ascend_o) ? $past(ext_addr_o) + `SCR_ADDR_STEP
      : $past(ext_addr_o) - `SCR_ADDR_STEP))
      else $error("address did not step");
   AST_WR_PULSE: assert property (ext_wr_o |=> !ext_wr_o [*8])
      else $error("write strobes too close");
   AST_SINGLE_ONE: assert property (single_instruction_o |-> wr_cnt <= 4'h1)
      else $error("second byte written in single mode");
   AST_SRST_PULSE: assert property (soft_reset_o |=> !soft_reset_o)
      else $error("soft reset not one cycle");
   AST_SRST_CFGB: assert property (soft_reset_o |->
      ##[0:2] (!single_instruction_o && !readback_main_o))
      else $error("soft reset left settings");
   AST_CFG_IDLE: assert property (cs_n_i [*6] |->
      $stable({wire_count_select_o, addr_ascend_o, lsb_first_o, single_instruction_o}))
      else $error("settings changed outside a frame");
endmodule
bind scr_top scr_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
   .sdio_oe_o(sdio_oe_o), .serial_out_pin_oe_o(serial_out_pin_oe_o),
   .wire_count_select_o(wire_count_select_o), .addr_ascend_o(addr_ascend_o),
   .lsb_first_o(lsb_first_o), .single_instruction_o(single_instruction_o),
   .readback_main_o(readback_main_o), .soft_reset_o(soft_reset_o),
   .ext_wr_o(ext_wr_o), .ext_addr_o(ext_addr_o));
`default_nettype wire

// [dv/tb_spi_config_and_id_registers.sv]
// Bench for the serial configuration and identification bank.
// Assumes the host model and the checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "scr_defs.vh"
module tb_spi_config_and_id_registers;
   localparam logic [15:0] PART = `SCR_ID_PART;
   logic clk_i, rst_i, sclk, cs_n, hsd, sd, so, sd_o, sd_oe, ext_wr;
   logic so_d, so_oe, srst;
   logic [6:0] st;
   logic [1:0] core;
   logic [8:0] temp;
   logic [7:0] band, stg, mn, ewd, spv;
   logic [3:0] bias;
   logic [14:0] ea;
   logic [63:0] rnd;
   logic [7:0] rq [$];
   logic [22:0] wq [$];
   logic [7:0] ids [0:6];
   logic [7:0] hi [0:14];
   int num_errors = 0;
   int tests_run = 0;
   int srst_cnt = 0;
   // Data wire: device wins while its enable is high
   assign sd = sd_oe ? sd_o : hsd;
   // Output pin shows the inverse while released, so a missing enable shows up
   assign so = so_oe ? so_d : ~so_d;
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   scr_host host (.clk_i(clk_i), .sd_i(sd), .so_i(so), .sclk_o(sclk), .cs_n_o(cs_n),
      .sdio_o(hsd));
   scr_top DUT (.clk_i(clk_i), .rst_i(rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdio_i(sd),
      .sdio_o(sd_o), .sdio_oe_o(sd_oe), .serial_out_pin_o(so_d), .serial_out_pin_oe_o(so_oe),
      .wire_count_select_o(), .addr_ascend_o(), .lsb_first_o(),
      .single_instruction_o(), .readback_main_o(), .soft_reset_o(srst),
      .ext_addr_o(ea), .ext_wr_o(ext_wr), .ext_wdata_o(ewd),
      .ext_rd_staged_i(stg), .ext_rd_main_i(mn),
      .clk2_en_i(st[6]), .clk1_en_i(st[5]), .sync_ok_i(st[4]), .ref_ok_i(st[3]),
      .adc_active_i(st[2]), .sequencer_active_flag_i(st[1]), .locked_i(st[0]),
      .vco_core_i(core), .chip_temp_i(temp), .vco_band_i(band), .vco_bias_i(bias));
   task automatic chk(input logic [22:0] seen, input logic [22:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      if (num_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic wr1(input logic [14:0] a, input logic [7:0] v);
      host.wd[0] = v;
      host.frame(1'b0, a, 1);
   endtask
   task automatic rd1(input logic [14:0] a, input logic [7:0] e);
      rq.push_back(e);
      host.frame(1'b1, a, 1);
   endtask
   // Each byte read against the oldest note
   always @(host.got) begin
      chk({15'h0, host.rbyte}, {15'h0, rq.size() ? rq.pop_front() : 8'hxx});
   end
   // Each write outside the bank against the oldest note, away from the launching edge
   always @(negedge clk_i) begin
      if (ext_wr === 1'b1) begin
         chk({ea, ewd}, wq.size() ? wq.pop_front() : 23'hx);
      end
      if (srst === 1'b1) begin
         srst_cnt++;
      end
   end
   // Watchdog
   initial begin
      repeat (90000) @(posedge clk_i);
      num_errors++;
      wrap_up();
   end
   // Main sequence
   initial begin
      rst_i = 1'b1;
      {st, core, temp, band, bias, stg, mn} = 46'h0;
      void'($urandom(32'h5D81FB6A));
      repeat (8) @(negedge clk_i);
      rst_i = 1'b0;
      rnd = {$urandom, $urandom};
      {st, core, temp, band, bias, stg, mn} = rnd[45:0];
      // Copies always differ so the source select is visible
      mn = ~stg;
      // Reset and identity bytes, stepping down
      ids = '{{`SCR_ID_GRADE, `SCR_ID_REV}, PART[15:8], PART[7:0], {4'h0, `SCR_ID_CLASS},
         8'h00, 8'h00, 8'h00};
      foreach (ids[i]) rq.push_back(ids[i]);
      host.frame(1'b1, 15'h0006, 7);
      wr1(15'h0000, 8'h24);
      rd1(15'h0000, 8'h24);
      // Status block, stepping up
      hi = '{8'h00, 8'h00, 8'h00, {st[6:4], 1'b0, st[3:0]}, 8'h00, {6'h00, core},
         temp[7:0], {7'h00, temp[8]}, 8'h00, band, 8'h00, {4'h0, bias}, 8'h00, 8'h00,
         `SCR_ID_SILICON};
      foreach (hi[i]) rq.push_back(hi[i]);
      host.frame(1'b1, 15'h0055, 15);
      // Streamed writes outside the bank
      for (int i = 0; i < 3; i++) begin
         host.wd[i] = 8'($urandom);
         wq.push_back({15'(i + 32), host.wd[i]});
      end
      host.frame(1'b0, 15'h0020, 3);
      // Staged and active readback
      rd1(15'h0030, stg);
      wr1(15'h0001, 8'h20);
      rd1(15'h0030, mn);
      // Spare byte, refused identity write
      spv = 8'($urandom);
      wr1(15'h000A, spv);
      rd1(15'h000A, spv);
      wr1(15'h0003, 8'hFF);
      rd1(15'h0003, {4'h0, `SCR_ID_CLASS});
      rd1(15'h0001, 8'h20);
      // Least significant bit first
      wr1(15'h0000, 8'h66);
      host.lsb = 1'b1;
      wr1(15'h000A, 8'h3A);
      rd1(15'h000A, 8'h3A);
      rd1(15'h0000, 8'h66);
      // Four-wire reads
      wr1(15'h0000, 8'h7E);
      host.four = 1'b1;
      rd1(15'h000A, 8'h3A);
      rd1(15'h0000, 8'h7E);
      // Single instruction drops the second byte
      wr1(15'h0001, 8'h80);
      host.wd[0] = 8'($urandom);
      host.wd[1] = ~host.wd[0];
      wq.push_back({15'h0040, host.wd[0]});
      host.frame(1'b0, 15'h0040, 2);
      rd1(15'h0001, 8'h80);
      // Soft reset keeps configuration A only
      wr1(15'h0000, 8'hFF);
      rd1(15'h0000, 8'h7E);
      rd1(15'h0001, 8'h00);
      rd1(15'h000A, 8'h00);
      chk(23'(srst_cnt), 23'h1);
      chk(23'(rq.size() + wq.size()), 23'h0);
      wrap_up();
   end
endmodule
`default_nettype wire

// [rtl/scr_defs.vh]
// Constants of the serial configuration and identification register bank.
// Holds definitions only; included by every design file of the bank.
`ifndef SCR_DEFS_VH
`define SCR_DEFS_VH

// Address width of the serial instruction
`define SCR_AW 15
`define SCR_IW 16
`define SCR_F_RNW 15
`define SCR_ADDR_STEP 15'h0001

// Register offsets
`define SCR_A_CFG_A 15'h0000
`define SCR_A_CFG_B 15'h0001
`define SCR_A_STATE 15'h0002
`define SCR_A_CLASS 15'h0003
`define SCR_A_PART_LO 15'h0004
`define SCR_A_PART_HI 15'h0005
`define SCR_A_GRADE 15'h0006
`define SCR_A_SPARE 15'h000A
`define SCR_A_IFREV 15'h000B
`define SCR_A_Z55 15'h0055
`define SCR_A_Z56 15'h0056
`define SCR_A_Z57 15'h0057
`define SCR_A_HEALTH 15'h0058
`define SCR_A_Z59 15'h0059
`define SCR_A_CORE 15'h005A
`define SCR_A_TEMP_LO 15'h005B
`define SCR_A_TEMP_HI 15'h005C
`define SCR_A_Z5D 15'h005D
`define SCR_A_BAND 15'h005E
`define SCR_A_Z5F 15'h005F
`define SCR_A_BIAS 15'h0060
`define SCR_A_Z61 15'h0061
`define SCR_A_Z62 15'h0062
`define SCR_A_SIVER 15'h0063

// Field positions in configuration A and B
`define SCR_F_WIRE 3
`define SCR_F_ASCEND 2
`define SCR_F_LSB 1
`define SCR_F_SRST 0
`define SCR_F_SINGLE 7
`define SCR_F_RDMAIN 5

// Reset values and counts
`define SCR_ZERO8 8'h00
`define SCR_SYNC_INIT 3'h2
`define SCR_INSTR_LAST 4'hF
`define SCR_BYTE_LAST 3'h7

// Identification values, arbitrary
`define SCR_ID_CLASS 4'hA
`define SCR_ID_PART 16'h3C5A
`define SCR_ID_GRADE 4'h3
`define SCR_ID_REV 4'h2
`define SCR_ID_IFREV 8'h2D
`define SCR_ID_SILICON 8'h4E

`endif

// [rtl/scr_rdmux.v]
// Read decode of the bank: picks the byte for the current address.
// Assumes status inputs come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "scr_defs.vh"
module scr_rdmux #(
   parameter [3:0] CLASS_CODE = `SCR_ID_CLASS,
   parameter [15:0] PART_CODE = `SCR_ID_PART,
   parameter [3:0] GRADE_CODE = `SCR_ID_GRADE,
   parameter [3:0] REV_CODE = `SCR_ID_REV,
   parameter [7:0] IFREV_CODE = `SCR_ID_IFREV,
   parameter [7:0] SILICON_CODE = `SCR_ID_SILICON
) (
   // Selected register
   input wire [`SCR_AW-1:0] addr_i,
   // Writable bank state
   input wire [3:0] cfg_a_lo_i,
   input wire [7:0] cfg_b_i,
   input wire [7:0] spare_i,
   // Status of the rest of the chip
   input wire [7:0] health_i,
   input wire [1:0] vco_core_i,
   input wire [8:0] chip_temp_i,
   input wire [7:0] vco_band_i,
   input wire [3:0] vco_bias_i,
   // Double-buffered registers kept elsewhere
   input wire [7:0] ext_rd_staged_i,
   input wire [7:0] ext_rd_main_i,
   // Result
   output reg [7:0] rd_data_o,
   output reg local_hit_o
);
   // Address decode
   always @* begin
      local_hit_o = 1'b1;
      case (addr_i)
         `SCR_A_CFG_A: rd_data_o = {cfg_a_lo_i[0], cfg_a_lo_i[1], cfg_a_lo_i[2],
                                    cfg_a_lo_i[3], cfg_a_lo_i};
         `SCR_A_CFG_B: rd_data_o = cfg_b_i;
         `SCR_A_CLASS: rd_data_o = {4'h0, CLASS_CODE};
         `SCR_A_PART_LO: rd_data_o = PART_CODE[7:0];
         `SCR_A_PART_HI: rd_data_o = PART_CODE[15:8];
         `SCR_A_GRADE: rd_data_o = {GRADE_CODE, REV_CODE};
         `SCR_A_SPARE: rd_data_o = spare_i;
         `SCR_A_IFREV: rd_data_o = IFREV_CODE;
         `SCR_A_HEALTH: rd_data_o = health_i;
         `SCR_A_CORE: rd_data_o = {6'h00, vco_core_i};
         `SCR_A_TEMP_LO: rd_data_o = chip_temp_i[7:0];
         `SCR_A_TEMP_HI: rd_data_o = {7'h00, chip_temp_i[8]};
         `SCR_A_BAND: rd_data_o = vco_band_i;
         `SCR_A_BIAS: rd_data_o = {4'h0, vco_bias_i};
         `SCR_A_SIVER: rd_data_o = SILICON_CODE;
         `SCR_A_STATE, `SCR_A_Z55, `SCR_A_Z56, `SCR_A_Z57, `SCR_A_Z59, `SCR_A_Z5D,
         `SCR_A_Z5F, `SCR_A_Z61, `SCR_A_Z62: rd_data_o = `SCR_ZERO8;
         default: begin
            // Outside the bank: staged or active copy
            local_hit_o = 1'b0;
            rd_data_o = cfg_b_i[`SCR_F_RDMAIN] ? ext_rd_main_i : ext_rd_staged_i;
         end
      endcase
   end
endmodule
`default_nettype wire

// [rtl/scr_sync.v]
// Two-flop synchroniser for a group of pin levels.
// Assumes each input is a slow level that may change at any time.
`timescale 1ns/1ps
`default_nettype none
`include "scr_defs.vh"
module scr_sync #(
   parameter W = 3,
   parameter [W-1:0] INIT = `SCR_SYNC_INIT
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Levels in and out
   input wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   genvar i;
   generate
      for (i = 0; i < W; i = i + 1) begin : g_bit
         reg meta;
         reg stable;
         // First flop feeds only the second
         always @(posedge clk_i) begin
            if (rst_i) begin
               meta <= INIT[i];
               stable <= INIT[i];
            end else begin
               meta <= d_i[i];
               stable <= meta;
            end
         end
         assign q_o[i] = stable;
      end
   endgenerate
endmodule
`default_nettype wire

// [rtl/scr_top.v]
// Serial interface engine with the configuration and identification bank.
// Assumes a host that runs the serial clock far slower than clk_i (at least
// eight clk_i periods per half cycle) and drives data on its falling edge.
`timescale 1ns/1ps
`default_nettype none
`include "scr_defs.vh"
module scr_top #(
   // Identification values, arbitrary
   parameter [3:0] CLASS_CODE = `SCR_ID_CLASS,
   parameter [15:0] PART_CODE = `SCR_ID_PART,
   parameter [3:0] GRADE_CODE = `SCR_ID_GRADE,
   parameter [3:0] REV_CODE = `SCR_ID_REV,
   parameter [7:0] IFREV_CODE = `SCR_ID_IFREV,
   parameter [7:0] SILICON_CODE = `SCR_ID_SILICON
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_i,
   // Serial pins
   input wire sclk_i,
   input wire cs_n_i,
   input wire sdio_i,
   output reg sdio_o,
   output reg sdio_oe_o,
   output reg serial_out_pin_o,
   output reg serial_out_pin_oe_o,
   // Interface settings
   output reg wire_count_select_o,
   output reg addr_ascend_o,
   output reg lsb_first_o,
   output reg single_instruction_o,
   output reg readback_main_o,
   output reg soft_reset_o,
   // Registers kept elsewhere in the chip
   output reg [`SCR_AW-1:0] ext_addr_o,
   output reg ext_wr_o,
   output reg [7:0] ext_wdata_o,
   input wire [7:0] ext_rd_staged_i,
   input wire [7:0] ext_rd_main_i,
   // Lock and health status
   input wire clk2_en_i,
   input wire clk1_en_i,
   input wire sync_ok_i,
   input wire ref_ok_i,
   input wire adc_active_i,
   input wire sequencer_active_flag_i,
   input wire locked_i,
   // Oscillator and temperature readback
   input wire [1:0] vco_core_i,
   input wire [8:0] chip_temp_i,
   input wire [7:0] vco_band_i,
   input wire [3:0] vco_bias_i
);
   // Frame states
   localparam [3:0] ST_IDLE = 4'b0001;
   localparam [3:0] ST_INSTR = 4'b0010;
   localparam [3:0] ST_DATA = 4'b0100;
   localparam [3:0] ST_HOLD = 4'b1000;

   // Synchronised pins
   wire [2:0] pins_s;
   wire sclk_s;
   wire cs_n_s;
   wire sdio_s;

   // Serial engine state
   reg [3:0] state;
   reg [3:0] bitcnt;
   reg [`SCR_IW-1:0] instr_sh;
   reg [7:0] data_sh;
   reg rnw;
   reg sclk_d;
   reg wr_stb;
   reg step_pend;
   reg load_pend;
   reg [7:0] rd_byte;

   // Reserved read-write bits of configuration B, and the spare byte
   reg [3:0] cfg_b_rsv;
   reg [7:0] spare_byte;

   // Derived terms
   wire sclk_rise;
   wire sclk_fall;
   wire [`SCR_IW-1:0] next_instr;
   wire [7:0] next_data;
   wire [2:0] tx_idx;
   wire tx_bit;
   wire [3:0] cfg_a_lo;
   wire [7:0] cfg_b;
   wire [7:0] health;
   wire [7:0] rd_data;
   wire local_hit;

   // Pin synchroniser
   scr_sync #(
      .W(3),
      .INIT(`SCR_SYNC_INIT)
   ) u_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({sclk_i, cs_n_i, sdio_i}),
      .q_o(pins_s)
   );

   assign sclk_s = pins_s[2];
   assign cs_n_s = pins_s[1];
   assign sdio_s = pins_s[0];

   // Serial clock edges seen from clk_i
   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;

   // Shift in the selected bit order
   assign next_instr = lsb_first_o ? {sdio_s, instr_sh[`SCR_IW-1:1]}
                                   : {instr_sh[`SCR_IW-2:0], sdio_s};
   assign next_data = lsb_first_o ? {sdio_s, data_sh[7:1]}
                                  : {data_sh[6:0], sdio_s};

   // Bit of the read byte due on the next falling edge
   assign tx_idx = lsb_first_o ? bitcnt[2:0] : (`SCR_BYTE_LAST - bitcnt[2:0]);
   assign tx_bit = rd_byte[tx_idx];

   // Register images for readback; soft reset bit always reads 0
   assign cfg_a_lo = {wire_count_select_o, addr_ascend_o, lsb_first_o, 1'b0};
   assign cfg_b = {single_instruction_o, cfg_b_rsv[3], readback_main_o, cfg_b_rsv[2],
                   1'b0, cfg_b_rsv[1], cfg_b_rsv[0], 1'b0};
   assign health = {clk2_en_i, clk1_en_i, sync_ok_i, 1'b0, ref_ok_i, adc_active_i,
                    sequencer_active_flag_i, locked_i};

   // Read decode
   scr_rdmux #(
      .CLASS_CODE(CLASS_CODE),
      .PART_CODE(PART_CODE),
      .GRADE_CODE(GRADE_CODE),
      .REV_CODE(REV_CODE),
      .IFREV_CODE(IFREV_CODE),
      .SILICON_CODE(SILICON_CODE)
   ) u_rdmux (
      .addr_i(ext_addr_o),
      .cfg_a_lo_i(cfg_a_lo),
      .cfg_b_i(cfg_b),
      .spare_i(spare_byte),
      .health_i(health),
      .vco_core_i(vco_core_i),
      .chip_temp_i(chip_temp_i),
      .vco_band_i(vco_band_i),
      .vco_bias_i(vco_bias_i),
      .ext_rd_staged_i(ext_rd_staged_i),
      .ext_rd_main_i(ext_rd_main_i),
      .rd_data_o(rd_data),
      .local_hit_o(local_hit)
   );

   // Frame engine: instruction, data bytes, address stepping, read drive
   always @(posedge clk_i) begin
      if (rst_i) begin
         state <= ST_IDLE;
         bitcnt <= 4'h0;
         instr_sh <= 16'h0000;
         data_sh <= `SCR_ZERO8;
         rnw <= 1'b0;
         sclk_d <= 1'b0;
         wr_stb <= 1'b0;
         step_pend <= 1'b0;
         load_pend <= 1'b0;
         rd_byte <= `SCR_ZERO8;
         ext_addr_o <= `SCR_A_CFG_A;
         ext_wr_o <= 1'b0;
         ext_wdata_o <= `SCR_ZERO8;
         sdio_o <= 1'b0;
         sdio_oe_o <= 1'b0;
         serial_out_pin_o <= 1'b0;
         serial_out_pin_oe_o <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
         wr_stb <= 1'b0;
         ext_wr_o <= 1'b0;
         step_pend <= 1'b0;
         load_pend <= 1'b0;
         // Capture read byte once the address has settled
         if (load_pend) begin
            rd_byte <= rd_data;
         end
         // Step after the byte's write strobe has used the address
         if (step_pend) begin
            if (addr_ascend_o) begin
               ext_addr_o <= ext_addr_o + `SCR_ADDR_STEP;
            end else begin
               ext_addr_o <= ext_addr_o - `SCR_ADDR_STEP;
            end
            load_pend <= 1'b1;
         end
         if (cs_n_s) begin
            // Chip select released: end of frame
            state <= ST_IDLE;
            bitcnt <= 4'h0;
            sdio_oe_o <= 1'b0;
            serial_out_pin_oe_o <= 1'b0;
         end else begin
            case (state)
               ST_IDLE: begin
                  state <= ST_INSTR;
                  bitcnt <= 4'h0;
               end
               ST_INSTR: begin
                  if (sclk_rise) begin
                     instr_sh <= next_instr;
                     bitcnt <= bitcnt + 4'h1;
                     if (bitcnt == `SCR_INSTR_LAST) begin
                        rnw <= next_instr[`SCR_F_RNW];
                        ext_addr_o <= next_instr[`SCR_AW-1:0];
                        load_pend <= 1'b1;
                        bitcnt <= 4'h0;
                        state <= ST_DATA;
                     end
                  end
               end
               ST_DATA: begin
                  if (sclk_rise) begin
                     data_sh <= next_data;
                     bitcnt <= bitcnt + 4'h1;
                     if (bitcnt[2:0] == `SCR_BYTE_LAST) begin
                        bitcnt <= 4'h0;
                        wr_stb <= ~rnw;
                        ext_wr_o <= ~rnw & ~local_hit;
                        ext_wdata_o <= next_data;
                        if (single_instruction_o) begin
                           state <= ST_HOLD;
                        end else begin
                           step_pend <= 1'b1;
                        end
                     end
                  end
                  // Read data leaves on the pin of the selected mode
                  if (sclk_fall && rnw) begin
                     sdio_o <= tx_bit;
                     serial_out_pin_o <= tx_bit;
                     sdio_oe_o <= ~wire_count_select_o;
                     serial_out_pin_oe_o <= wire_count_select_o;
                  end
               end
               ST_HOLD: begin
                  // Single instruction done; ignore clocks until release
                  sdio_oe_o <= 1'b0;
                  serial_out_pin_oe_o <= 1'b0;
               end
               default: begin
                  state <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Writes to the bank; soft reset spares configuration A
   always @(posedge clk_i) begin
      if (rst_i) begin
         wire_count_select_o <= 1'b0;
         addr_ascend_o <= 1'b0;
         lsb_first_o <= 1'b0;
         single_instruction_o <= 1'b0;
         readback_main_o <= 1'b0;
         cfg_b_rsv <= 4'h0;
         spare_byte <= `SCR_ZERO8;
         soft_reset_o <= 1'b0;
      end else begin
         soft_reset_o <= 1'b0;
         if (wr_stb) begin
            case (ext_addr_o)
               `SCR_A_CFG_A: begin
                  // Low nibble is the master copy of the mirrored pairs
                  wire_count_select_o <= ext_wdata_o[`SCR_F_WIRE];
                  addr_ascend_o <= ext_wdata_o[`SCR_F_ASCEND];
                  lsb_first_o <= ext_wdata_o[`SCR_F_LSB];
                  if (ext_wdata_o[`SCR_F_SRST]) begin
                     soft_reset_o <= 1'b1;
                     single_instruction_o <= 1'b0;
                     readback_main_o <= 1'b0;
                     cfg_b_rsv <= 4'h0;
                     spare_byte <= `SCR_ZERO8;
                  end
               end
               `SCR_A_CFG_B: begin
                  single_instruction_o <= ext_wdata_o[`SCR_F_SINGLE];
                  readback_main_o <= ext_wdata_o[`SCR_F_RDMAIN];
                  cfg_b_rsv <= {ext_wdata_o[6], ext_wdata_o[4], ext_wdata_o[2], ext_wdata_o[1]};
               end
               `SCR_A_SPARE: begin
                  spare_byte <= ext_wdata_o;
               end
               default: begin
                  // Read-only or outside the bank: nothing kept here
                  spare_byte <= spare_byte;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire
